// ==== hdl/pdm_pkg.sv ====
`default_nettype none
package pdm_pkg;
   localparam int PORT_A_WIDTH = 8;
   localparam int IRQ_WIDTH = 8;
   localparam int WDT_WIDTH = 18;
   // Register byte addresses
   localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WDT_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_WDT_COUNT = 8'h10;
   localparam logic [7:0] ADDR_WDT_LIMIT = 8'h14;
   // Clock control fields
   localparam int CC_FAST_KEEP = 0;
   localparam int CC_SLOW_KEEP = 1;
   localparam int CC_SLOW_SRC = 2;
   localparam int CC_SYS_SLOW = 3;
   // Status fields
   localparam int ST_PDF = 0;
   localparam int ST_TO = 1;
   localparam int ST_MODE = 2;
   localparam int ST_WAIT_OSC = 7;
   localparam int ST_SLOW_STABLE = 8;
   localparam logic [31:0] WDT_LIMIT_RESET = 32'h0003FFFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_SLEEP = 5'h02,
      ST_IDLE0 = 5'h04,
      ST_IDLE1 = 5'h08,
      ST_IDLE2 = 5'h10
   } pd_state_t;
   typedef enum logic [1:0] {
      RES_NONE = 2'h0,
      RES_NEXT = 2'h1,
      RES_IRQ = 2'h2,
      RES_WDT = 2'h3
   } resume_t;
endpackage
`default_nettype wire

// ==== hdl/wake_edge_detect.sv ====
`default_nettype none
module wake_edge_detect (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [pdm_pkg::PORT_A_WIDTH-1:0] port_a_pins,
   input wire logic [pdm_pkg::PORT_A_WIDTH-1:0] port_a_wake_enable,
   output logic port_a_wake
);
   logic [pdm_pkg::PORT_A_WIDTH-1:0] prev_q;
   logic [pdm_pkg::PORT_A_WIDTH-1:0] fall;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '1;
      end else begin
         prev_q <= port_a_pins;
      end
   end
   genvar i;
   generate
      for (i = 0; i < pdm_pkg::PORT_A_WIDTH; i++) begin : g_pin
         // Only enabled pins, only high-to-low
         assign fall[i] = port_a_wake_enable[i] & prev_q[i] & ~port_a_pins[i];
      end
   endgenerate
   assign port_a_wake = |fall;
endmodule
`default_nettype wire

// ==== hdl/power_down_mode_wake_control.sv ====
// Functional notes
// - Halt with both keep bits 0 enters sleep; only watchdog runs.
// - Halt with fast keep 0, slow keep 1 enters idle0; slow clock runs.
// - Halt with both keep bits 1 enters idle1; both clocks run.
// - Halt with fast keep 1, slow keep 0 enters idle2; fast clock runs.
// - Power-down halts fetch at halt; memory, registers and ports kept.
// - Halt sets powered-down flag and clears watchdog expiry flag.
// - Power-down entry clears watchdog counter; counts on only if enabled.
// - Wake on port A fall, external clear pin, interrupt, watchdog overflow.
// - External clear pin wake gives a full system reset.
// - Watchdog overflow in power-down sets expiry flag, resets PC and SP only.
// - Powered-down flag cleared by power-up or clear-watchdog, set by halt.
// - Per-pin port A wake enable; only enabled pins, only falling edges.
// - Port A wake resumes at instruction after halt.
// - Disabled or stack-full wake interrupt resumes after halt, stays pending.
// - Interrupt already pending before power-down cannot wake that period.
// - Wake from sleep to fast waits for selected fast oscillator stable.
// - Fast and slow oscillators settle separately; slow may lag first fetch.
// - Peripheral clock follows system clock source, fast or slow.
// - Slow clock from slow crystal or internal slow osc per select bit.
//
// The address map and register access over AHB-Lite were left to the implementer.
`default_nettype none
module power_down_mode_wake_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic halt_exec,
   input wire logic clear_watchdog_exec,
   input wire logic [pdm_pkg::PORT_A_WIDTH-1:0] port_a_pins,
   input wire logic external_clear_pin_n,
   input wire logic [pdm_pkg::IRQ_WIDTH-1:0] irq_request,
   input wire logic [pdm_pkg::IRQ_WIDTH-1:0] irq_enable,
   input wire logic stack_full,
   input wire logic fast_src_is_crystal,
   input wire logic internal_fast_osc_stable,
   input wire logic crystal_fast_osc_stable,
   input wire logic slow_crystal_stable,
   input wire logic fast_osc_clk,
   input wire logic slow_crystal_clk,
   input wire logic slow_internal_clk,
   output logic fast_clock_en,
   output logic slow_clock_en,
   output logic core_clock_en,
   output logic periph_clock_src_slow,
   output logic slow_clock,
   output logic fetch_hold,
   output logic resume_next,
   output logic irq_take,
   output logic pc_sp_reset,
   output logic system_reset_req,
   output logic powered_down_flag,
   output logic watchdog_expiry_flag
);
   logic [3:0] clk_ctrl_q;
   logic [pdm_pkg::PORT_A_WIDTH-1:0] port_a_wake_enable_q;
   logic watchdog_enable_q;
   logic [pdm_pkg::WDT_WIDTH-1:0] watchdog_counter_q;
   logic [pdm_pkg::WDT_WIDTH-1:0] wdt_limit_q;
   logic pdf_q;
   logic to_q;
   pdm_pkg::pd_state_t state_q;
   logic osc_wait_q;
   logic [pdm_pkg::IRQ_WIDTH-1:0] irq_masked_q;
   logic [pdm_pkg::IRQ_WIDTH-1:0] irq_pending_q;
   logic [pdm_pkg::IRQ_WIDTH-1:0] new_irq;
   logic clr_pin_q;
   logic resume_next_q;
   logic irq_take_q;
   logic pc_sp_reset_q;
   logic sys_reset_q;
   logic [7:0] addr_q;
   logic wr_q;
   logic rd_pend;
   logic [31:0] rdata_q;
   logic port_a_wake;
   logic asleep;
   logic wdt_overflow;
   logic wake_irq;
   logic wake_any;
   logic fast_stable;
   logic bus_req;

   // Bus slave: zero wait states, OKAY always
   assign bus_req = hsel & hready & htrans[1] & (hsize == pdm_pkg::HSIZE_WORD);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_pend <= 1'b0;
      end else begin
         addr_q <= haddr[7:0];
         wr_q <= bus_req & hwrite;
         rd_pend <= bus_req & ~hwrite;
      end
   end

   // Read data is captured in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else if (bus_req & ~hwrite) begin
         unique case (haddr[7:0])
            pdm_pkg::ADDR_CLOCK_CTRL: rdata_q <= {28'h0000000, clk_ctrl_q};
            pdm_pkg::ADDR_WAKE_EN: rdata_q <= {24'h000000, port_a_wake_enable_q};
            pdm_pkg::ADDR_STATUS: rdata_q <= {23'h000000, slow_crystal_stable,
                                              osc_wait_q, state_q, to_q, pdf_q};
            pdm_pkg::ADDR_WDT_CTRL: rdata_q <= {31'h00000000, watchdog_enable_q};
            pdm_pkg::ADDR_WDT_COUNT: rdata_q <= {14'h0000, watchdog_counter_q};
            pdm_pkg::ADDR_WDT_LIMIT: rdata_q <= {14'h0000, wdt_limit_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_ctrl_q <= 4'h0;
         port_a_wake_enable_q <= '0;
         watchdog_enable_q <= 1'b1;
         wdt_limit_q <= pdm_pkg::WDT_LIMIT_RESET[pdm_pkg::WDT_WIDTH-1:0];
      end else if (wr_q) begin
         unique case (addr_q)
            pdm_pkg::ADDR_CLOCK_CTRL: clk_ctrl_q <= hwdata[3:0];
            pdm_pkg::ADDR_WAKE_EN:
               port_a_wake_enable_q <= hwdata[pdm_pkg::PORT_A_WIDTH-1:0];
            pdm_pkg::ADDR_WDT_CTRL: watchdog_enable_q <= hwdata[0];
            pdm_pkg::ADDR_WDT_LIMIT: wdt_limit_q <= hwdata[pdm_pkg::WDT_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   wake_edge_detect u_wake_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .port_a_pins(port_a_pins),
      .port_a_wake_enable(port_a_wake_enable_q),
      .port_a_wake(port_a_wake)
   );

   assign asleep = (state_q != pdm_pkg::ST_RUN);
   assign wdt_overflow = watchdog_enable_q & (watchdog_counter_q == wdt_limit_q);

   // Requests already set at entry are masked from waking this period
   assign new_irq = irq_request & ~irq_masked_q;
   assign wake_irq = |new_irq;
   assign wake_any = port_a_wake | wake_irq | wdt_overflow | clr_pin_q;
   assign fast_stable = fast_src_is_crystal ? crystal_fast_osc_stable
                                            : internal_fast_osc_stable;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_pin_q <= 1'b0;
      end else begin
         clr_pin_q <= ~external_clear_pin_n;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= pdm_pkg::ST_RUN;
      end else if (!asleep) begin
         if (halt_exec) begin
            unique case ({clk_ctrl_q[pdm_pkg::CC_FAST_KEEP], clk_ctrl_q[pdm_pkg::CC_SLOW_KEEP]})
               2'h0: state_q <= pdm_pkg::ST_SLEEP;
               2'h1: state_q <= pdm_pkg::ST_IDLE0;
               2'h3: state_q <= pdm_pkg::ST_IDLE1;
               2'h2: state_q <= pdm_pkg::ST_IDLE2;
            endcase
         end
      end else if (wake_any) begin
         state_q <= pdm_pkg::ST_RUN;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_masked_q <= '0;
      end else if (!asleep && halt_exec) begin
         irq_masked_q <= irq_request;
      end else if (asleep) begin
         irq_masked_q <= irq_masked_q & irq_request;
      end
   end

   // Interrupt that woke the core but could not be serviced yet
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_pending_q <= '0;
      end else if (asleep && wake_any) begin
         irq_pending_q <= new_irq & ~(irq_enable & {pdm_pkg::IRQ_WIDTH{~stack_full}});
      end else begin
         irq_pending_q <= irq_pending_q & irq_request &
                          ~(irq_enable & {pdm_pkg::IRQ_WIDTH{~stack_full}});
      end
   end

   // Fetch held after a sleep wake to the fast system clock until the fast oscillator reports stable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_wait_q <= 1'b0;
      end else if (state_q == pdm_pkg::ST_SLEEP && wake_any && !clr_pin_q &&
                   !clk_ctrl_q[pdm_pkg::CC_SYS_SLOW]) begin
         osc_wait_q <= ~fast_stable;
      end else if (fast_stable) begin
         osc_wait_q <= 1'b0;
      end
   end

   // Wake outcome pulses, one cycle each
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_next_q <= 1'b0;
         irq_take_q <= 1'b0;
         pc_sp_reset_q <= 1'b0;
         sys_reset_q <= 1'b0;
      end else begin
         sys_reset_q <= asleep & clr_pin_q;
         pc_sp_reset_q <= asleep & ~clr_pin_q & wdt_overflow;
         irq_take_q <= asleep & ~clr_pin_q & ~wdt_overflow &
                       |(new_irq & irq_enable) & ~stack_full;
         resume_next_q <= asleep & ~clr_pin_q & ~wdt_overflow & wake_any &
                          ~(|(new_irq & irq_enable) & ~stack_full);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pdf_q <= 1'b0;
      end else if (!asleep && halt_exec) begin
         pdf_q <= 1'b1;
      end else if (clear_watchdog_exec || (asleep && clr_pin_q)) begin
         pdf_q <= 1'b0;
      end
   end

   // Overflow setting the flag wins over the halt clearing it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         to_q <= 1'b0;
      end else if (wdt_overflow) begin
         to_q <= 1'b1;
      end else if (!asleep && halt_exec) begin
         to_q <= 1'b0;
      end else if (asleep && clr_pin_q) begin
         to_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         watchdog_counter_q <= '0;
      end else if ((!asleep && halt_exec) || clear_watchdog_exec || clr_pin_q ||
                   wdt_overflow) begin
         watchdog_counter_q <= '0;
      end else if (watchdog_enable_q) begin
         watchdog_counter_q <= watchdog_counter_q + 1'b1;
      end
   end

   // Core clock gated in every power-down mode; state kept by not clocking
   assign core_clock_en = ~asleep & ~osc_wait_q;
   assign fetch_hold = asleep | osc_wait_q;
   assign fast_clock_en = (state_q == pdm_pkg::ST_RUN) | (state_q == pdm_pkg::ST_IDLE1) |
                          (state_q == pdm_pkg::ST_IDLE2);
   // Slow clock enable independent of the fast settle wait
   assign slow_clock_en = (state_q == pdm_pkg::ST_RUN) | (state_q == pdm_pkg::ST_IDLE0) |
                          (state_q == pdm_pkg::ST_IDLE1);
   assign periph_clock_src_slow = clk_ctrl_q[pdm_pkg::CC_SYS_SLOW];
   // Plain mux; a glitch-free switch is expected downstream
   assign slow_clock = clk_ctrl_q[pdm_pkg::CC_SLOW_SRC] ? slow_crystal_clk
                                                         : slow_internal_clk;
   assign resume_next = resume_next_q;
   assign irq_take = irq_take_q;
   assign pc_sp_reset = pc_sp_reset_q;
   assign system_reset_req = sys_reset_q;
   assign powered_down_flag = pdf_q;
   assign watchdog_expiry_flag = to_q;

   logic unused_ok;
   assign unused_ok = fast_osc_clk ^ rd_pend ^ (|irq_pending_q) ^ haddr[31] ^ hwdata[31];
endmodule
`default_nettype wire

// ==== tb/pdm_properties.sv ====
`default_nettype none
module pdm_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic halt_exec,
   input wire logic clear_watchdog_exec,
   input wire logic fast_src_is_crystal,
   input wire logic internal_fast_osc_stable,
   input wire logic crystal_fast_osc_stable,
   input wire logic fast_clock_en,
   input wire logic slow_clock_en,
   input wire logic core_clock_en,
   input wire logic periph_clock_src_slow,
   input wire logic fetch_hold,
   input wire logic resume_next,
   input wire logic irq_take,
   input wire logic pc_sp_reset,
   input wire logic system_reset_req,
   input wire logic powered_down_flag,
   input wire logic watchdog_expiry_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Wake cycle excluded: the enables move there, and the fast settle wait follows it
   sequence in_down;
      !core_clock_en ##1 (!core_clock_en &&
         !(resume_next || irq_take || pc_sp_reset || system_reset_req));
   endsequence
   sequence halt_taken;
      halt_exec && core_clock_en;
   endsequence
   halt_enter_a: assert property (halt_taken |=> !core_clock_en && powered_down_flag)
      else $error("halt did not enter power-down with flag set");
   mode_hold_a: assert property (in_down |-> $stable(fast_clock_en) && $stable(slow_clock_en))
      else $error("clock enables moved during power-down");
   outcome_onehot_a: assert property ($onehot0({resume_next, irq_take, pc_sp_reset, system_reset_req}))
      else $error("more than one wake outcome");
   wake_source_a: assert property ((resume_next || irq_take || pc_sp_reset) |->
      !$past(core_clock_en) || !$past(core_clock_en, 2)) else $error("wake outcome outside power-down");
   clear_pin_reset_a: assert property (system_reset_req |->
      ##[0:1] (!powered_down_flag && !watchdog_expiry_flag)) else $error("flags kept on pin reset");
   wdt_wake_flag_a: assert property (pc_sp_reset |-> powered_down_flag ##[0:1] watchdog_expiry_flag)
      else $error("watchdog wake flags wrong");
   pdf_clear_a: assert property (clear_watchdog_exec && !halt_exec |=> !powered_down_flag)
      else $error("powered-down flag not cleared");
   osc_wait_a: assert property ((resume_next || irq_take || pc_sp_reset) && fetch_hold &&
      !periph_clock_src_slow &&
      !(fast_src_is_crystal ? crystal_fast_osc_stable : internal_fast_osc_stable) |=> fetch_hold)
      else $error("fetch released before oscillator stable");
endmodule
bind power_down_mode_wake_control pdm_checker pdm_checker_inst (.*);
`default_nettype wire

// ==== tb/core_model.sv ====
`default_nettype none
module core_model #(parameter int SETTLE = 8) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic fast_clock_en,
   input wire logic fetch_hold,
   output logic halt_exec,
   output logic clear_watchdog_exec,
   output logic crystal_fast_osc_stable,
   output logic internal_fast_osc_stable,
   output logic slow_crystal_stable
);
   timeunit 1ns;
   timeprecision 1ps;
   int settle_q;
   initial begin
      halt_exec = 1'b0;
      clear_watchdog_exec = 1'b0;
   end
   assign internal_fast_osc_stable = 1'b1;
   assign slow_crystal_stable = 1'b1;
   // Crystal restarts from scratch whenever its clock was gated
   assign crystal_fast_osc_stable = (settle_q == SETTLE);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) settle_q <= SETTLE;
      else if (!fast_clock_en) settle_q <= 0;
      else if (settle_q < SETTLE) settle_q <= settle_q + 1;
   end
   // A held core issues nothing
   task automatic issue(input logic h);
      while (fetch_hold !== 1'b0) @(posedge hclk);
      @(posedge hclk);
      if (h) halt_exec <= 1'b1;
      else clear_watchdog_exec <= 1'b1;
      @(posedge hclk);
      halt_exec <= 1'b0;
      clear_watchdog_exec <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== tb/power_down_mode_wake_control_tb.sv ====
`default_nettype none
module power_down_mode_wake_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = pdm_pkg::HSIZE_WORD;
   logic halt_exec, clear_watchdog_exec, stack_full = 0, external_clear_pin_n = 1;
   logic [7:0] port_a_pins = 8'hFF, irq_request = 0, irq_enable = 0;
   logic fast_src_is_crystal = 1, fast_osc_clk = 0, slow_crystal_clk = 0, slow_internal_clk;
   logic internal_fast_osc_stable, crystal_fast_osc_stable, slow_crystal_stable;
   logic fast_clock_en, slow_clock_en, core_clock_en, periph_clock_src_slow, slow_clock;
   logic fetch_hold, resume_next, irq_take, pc_sp_reset, system_reset_req;
   logic powered_down_flag, watchdog_expiry_flag;
   logic [3:0] pulses;
   int pc[4] = '{0, 0, 0, 0}, p0[4], error_cnt = 0, comparisons = 0;
   logic [4:0] mode_exp[4] = '{5'h02, 5'h10, 5'h04, 5'h08};
   power_down_mode_wake_control power_down_mode_wake_control_inst (.*);
   core_model core_model_inst (.hclk(hclk), .hresetn(hresetn), .fast_clock_en(fast_clock_en),
      .fetch_hold(fetch_hold), .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec),
      .crystal_fast_osc_stable(crystal_fast_osc_stable),
      .internal_fast_osc_stable(internal_fast_osc_stable),
      .slow_crystal_stable(slow_crystal_stable));
   always #2 hclk = ~hclk;
   assign hready = hreadyout;
   assign slow_internal_clk = ~slow_crystal_clk;
   assign pulses = {system_reset_req, pc_sp_reset, irq_take, resume_next};
   always @(posedge hclk) begin
      slow_crystal_clk <= ~slow_crystal_clk;
      for (int i = 0; i < 4; i++) if (pulses[i] === 1'b1) pc[i]++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= pdm_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h00000000, r);
      chk(n, e, r & m);
   endtask
   // Waits on the pulse counters so a one-cycle outcome is never missed
   task automatic out_chk(input string n, input int k);
      int t;
      t = 0;
      while (pc == p0 && t < 100) begin
         @(negedge hclk);
         t++;
      end
      for (int i = 0; i < 4; i++) chk(n, 32'(i == k), 32'(pc[i] - p0[i]));
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd("status_reset", pdm_pkg::ADDR_STATUS, 32'h0000007F, 32'h00000004);
      rd("limit_reset", pdm_pkg::ADDR_WDT_LIMIT, '1, pdm_pkg::WDT_LIMIT_RESET);
      rd("unmapped", 8'h40, '1, 32'h00000000);
      $display("registers test done");
      wr(pdm_pkg::ADDR_CLOCK_CTRL, 32'h0000000C);
      @(negedge hclk);
      chk("periph_slow", 1, periph_clock_src_slow);
      chk("slow_from_crystal", slow_crystal_clk, slow_clock);
      wr(pdm_pkg::ADDR_CLOCK_CTRL, 32'h00000000);
      @(negedge hclk);
      chk("periph_fast", 0, periph_clock_src_slow);
      chk("slow_from_internal", slow_internal_clk, slow_clock);
      $display("clock source test done");
      wr(pdm_pkg::ADDR_WAKE_EN, 32'h00000001);
      wr(pdm_pkg::ADDR_WDT_LIMIT, 32'h00000010);
      p0 = pc;
      core_model_inst.issue(1'b1);
      out_chk("wdt_wake", 2);
      rd("wdt_flags", pdm_pkg::ADDR_STATUS, 32'h00000003, 32'h00000003);
      wr(pdm_pkg::ADDR_WDT_LIMIT, pdm_pkg::WDT_LIMIT_RESET);
      core_model_inst.issue(1'b0);
      rd("pdf_cleared", pdm_pkg::ADDR_STATUS, 32'h00000003, 32'h00000002);
      $display("watchdog test done");
      for (int k = 0; k < 4; k++) begin
         wr(pdm_pkg::ADDR_CLOCK_CTRL, 32'(k));
         core_model_inst.issue(1'b1);
         rd("mode", pdm_pkg::ADDR_STATUS, 32'h7F, {25'h0, mode_exp[k], 2'h1});
         rd("wdt_cleared", pdm_pkg::ADDR_WDT_COUNT, 32'hFFFFFFE0, 32'h0);
         chk("clocks", 32'(k[1:0]), {30'h0, slow_clock_en, fast_clock_en});
         chk("core_halted", 0, core_clock_en);
         p0 = pc;
         @(posedge hclk);
         port_a_pins <= 8'hFE;
         out_chk("port_wake", 0);
         if (k == 0) begin
            chk("osc_hold", 1, fetch_hold);
            while (fetch_hold !== 1'b0) @(negedge hclk);
            chk("osc_ready", 1, crystal_fast_osc_stable);
         end
         @(posedge hclk);
         port_a_pins <= 8'hFF;
         $display("mode %0d test done", k);
      end
      // Internal fast source is already stable, so a sleep wake must not hold fetch
      wr(pdm_pkg::ADDR_CLOCK_CTRL, 32'h00000000);
      fast_src_is_crystal <= 1'b0;
      core_model_inst.issue(1'b1);
      p0 = pc;
      @(posedge hclk);
      port_a_pins <= 8'hFE;
      out_chk("internal_wake", 0);
      chk("internal_no_hold", 0, fetch_hold);
      @(posedge hclk);
      port_a_pins <= 8'hFF;
      fast_src_is_crystal <= 1'b1;
      $display("internal source test done");
      @(posedge hclk);
      port_a_pins <= 8'hFE;
      irq_enable <= 8'h01;
      irq_request <= 8'h04;
      core_model_inst.issue(1'b1);
      p0 = pc;
      @(posedge hclk);
      port_a_pins <= 8'hFD;
      repeat (10) @(posedge hclk);
      chk("no_wake", 0, 32'(pc != p0));
      irq_request <= 8'h05;
      out_chk("irq_wake", 1);
      @(posedge hclk);
      irq_request <= 8'h00;
      port_a_pins <= 8'hFF;
      core_model_inst.issue(1'b1);
      p0 = pc;
      @(posedge hclk);
      stack_full <= 1'b1;
      irq_request <= 8'h01;
      out_chk("irq_stack_full", 0);
      @(posedge hclk);
      stack_full <= 1'b0;
      irq_request <= 8'h00;
      core_model_inst.issue(1'b1);
      p0 = pc;
      @(posedge hclk);
      external_clear_pin_n <= 1'b0;
      out_chk("clear_pin", 3);
      @(posedge hclk);
      external_clear_pin_n <= 1'b1;
      rd("reset_flags", pdm_pkg::ADDR_STATUS, 32'h00000003, 32'h00000000);
      $display("wake source test done");
      test_done();
   end
endmodule
`default_nettype wire
